// file: pkg/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// structure sizes
`define SEQ_COUNT 3
`define SAMPLES_MAX 4
`define SEL_W 3
`define RESULT_W 10
`define FIFO_DEPTH_MAX 4
`define PTR_W 2
`define CNT_W 3
`define ADDR_W 8
`define DATA_W 32
`define REG12_W 16
`define IRQ_W 6

// per-sequencer depth of samples and results
`define SAMPLES_12 4
`define SAMPLES_3 1
`define FIFO_DEPTH_12 4
`define FIFO_DEPTH_3 1

// register byte offsets
`define OFS_SEQ1_INSEL 8'h70
`define OFS_SEQ1_CTL 8'h74
`define OFS_SEQ1_FIFO 8'h78
`define OFS_SEQ1_FSTAT 8'h7c
`define OFS_SEQ2_INSEL 8'h90
`define OFS_SEQ2_CTL 8'h94
`define OFS_SEQ2_FIFO 8'h98
`define OFS_SEQ2_FSTAT 8'h9c
`define OFS_SEQ3_INSEL 8'hb0
`define OFS_SEQ3_CTL 8'hb4
`define OFS_SEQ3_FIFO 8'hb8
`define OFS_SEQ3_FSTAT 8'hbc
`define OFS_IRQ_STATUS 8'hc0
`define OFS_IRQ_MASK 8'hc4

// reset values and writable masks
`define CTL12_RST 16'h2000
`define CTL12_WMASK 16'h6667
`define INSEL12_WMASK 16'h7777
`define CTL3_RST 3'h2
`define CTL3_WMASK 3'h6

// control field positions
`define CTL_SINGLE_BIT 0
`define CTL_LAST0_BIT 1
`define CTL_IE0_BIT 2
`define CTL_STRIDE 4

// fifo status field positions
`define FSTAT_FULL_BIT 12
`define FSTAT_EMPTY_BIT 8
`define FSTAT_HPTR_LSB 4

// interrupt status layout
`define IRQ_OVF_LSB 3

`endif

// file: pkg/adc_seq_pkg.sv
`include "adc_seq_cfg.svh"

package adc_seq_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_REQ = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_e;

    typedef logic [`SEL_W-1:0] sel_t;
    typedef logic [`RESULT_W-1:0] result_t;

    typedef struct packed {
        logic [`SAMPLES_MAX-1:0] irq_enable;
        logic [`SAMPLES_MAX-1:0] is_last;
        logic single_sample_per_trigger;
    } seq_cfg_s;

    typedef struct packed {
        seq_state_e state;
        logic [`PTR_W-1:0] pos;
    } walker_st_s;

    typedef struct packed {
        logic req;
        sel_t input_sel;
        logic sample_done;
        logic sample_irq;
    } walker_out_s;

    typedef struct packed {
        logic [`REG12_W-1:0] seq1_sample_control;
        logic [`REG12_W-1:0] seq1_input_select;
        logic [`REG12_W-1:0] seq2_sample_control;
        logic [`REG12_W-1:0] seq2_input_select;
        sel_t seq3_input_select;
        logic [2:0] seq3_sample_control;
        logic [`IRQ_W-1:0] irq_status;
        logic [`IRQ_W-1:0] irq_mask;
        logic [`SEQ_COUNT-1:0][`FIFO_DEPTH_MAX-1:0][`RESULT_W-1:0] fifo;
        logic [`SEQ_COUNT-1:0][`PTR_W-1:0] head;
        logic [`SEQ_COUNT-1:0][`PTR_W-1:0] tail;
        logic [`SEQ_COUNT-1:0][`CNT_W-1:0] level;
        logic [`DATA_W-1:0] rdata;
        logic conv_start;
        sel_t conv_input;
        logic [1:0] owner;
        logic busy;
        logic irq;
    } ctl_st_s;

endpackage

// file: rtl/seq_walker.sv
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module seq_walker #(
    parameter int SAMPLES = `SAMPLES_12
) (
    input wire logic i_clk,                                        // system clock
    input wire logic i_rst_n,                                      // sync reset, active low
    input wire logic i_trig,                                       // start pulse
    input wire adc_seq_pkg::seq_cfg_s i_cfg,                       // per-sample flags
    input wire logic [`SAMPLES_MAX-1:0][`SEL_W-1:0] i_input_sel,   // per-sample input
    input wire logic i_grant,                                      // converter taken
    input wire logic i_done,                                       // conversion finished
    output adc_seq_pkg::walker_out_s o_out                         // request and events
);

    localparam logic [`PTR_W-1:0] LAST_POS = `PTR_W'(SAMPLES - 1);

    adc_seq_pkg::walker_st_s st_ff;
    adc_seq_pkg::walker_st_s nxt_st;

    // walk the sample positions from the first, stop at the end flag
    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            adc_seq_pkg::SEQ_IDLE: begin
                if (i_trig) begin
                    nxt_st.state = adc_seq_pkg::SEQ_REQ;
                end
            end
            adc_seq_pkg::SEQ_REQ: begin
                if (i_grant) begin
                    nxt_st.state = adc_seq_pkg::SEQ_WAIT;
                end
            end
            adc_seq_pkg::SEQ_WAIT: begin
                if (i_done) begin
                    // last position also ends a sequence with no end flag set
                    if (i_cfg.is_last[st_ff.pos] || st_ff.pos == LAST_POS) begin
                        nxt_st.pos = '0;
                        nxt_st.state = adc_seq_pkg::SEQ_IDLE;
                    end else begin
                        nxt_st.pos = st_ff.pos + 1'b1;
                        // single mode: keep the advanced position, wait for next trigger
                        if (i_cfg.single_sample_per_trigger) begin
                            nxt_st.state = adc_seq_pkg::SEQ_IDLE;
                        end else begin
                            nxt_st.state = adc_seq_pkg::SEQ_REQ;
                        end
                    end
                end
            end
            default: begin
                nxt_st.state = adc_seq_pkg::SEQ_IDLE;
            end
        endcase
    end

    // request and per-sample events
    always_comb begin
        o_out.req = (st_ff.state == adc_seq_pkg::SEQ_REQ);
        o_out.input_sel = i_input_sel[st_ff.pos];
        o_out.sample_done = (st_ff.state == adc_seq_pkg::SEQ_WAIT) && i_done;
        o_out.sample_irq = o_out.sample_done && i_cfg.irq_enable[st_ff.pos];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= '{state: adc_seq_pkg::SEQ_IDLE, pos: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// file: rtl/adc_sample_sequence_control.sv
// Overview of operation
// - sequencers 1 and 2 each own a control register, 16 low bits used
// - sequencer 1 control at 0x74, sequencer 2 control at 0x94
// - fourth-sample interrupt enable, bit 14, resets 0, raises interrupt after fourth sample
// - third-sample interrupt enable, bit 10, resets 0, raises interrupt after third sample
// - second-sample interrupt enable, bit 6, resets 0, raises interrupt after second sample
// - first-sample interrupt enable, bit 2, all three sequencers, resets 0
// - fourth-sample end flag, bit 13, resets 1, ends sequence there
// - third-sample end flag, bit 9, resets 0, ends sequence there
// - second-sample end flag, bit 5, resets 0, ends sequence there
// - first-sample end flag, bit 1, resets 0 on sequencers 1 and 2
// - single-sample-per-trigger bit 0 resets 0, one sample per trigger
// - sequencer 3 input select at 0xb0, bits 2:0, resets 0
// - sequencer 3 control at 0xb4, first end flag resets 1
// - reserved bits read zero, writes to them ignored
// - sequencers 1 and 2 have a 3-bit input select per sample
// - result fifo read gives 10-bit result in bits 9:0, rest zero
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_sample_sequence_control #(
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic i_clk,                          // system clock, 10 MHz
    input wire logic i_rst_n,                        // sync reset, active low
    input wire logic [ADDR_W-1:0] i_addr,            // register byte address
    input wire logic [`DATA_W-1:0] i_wdata,          // write data
    input wire logic i_wr,                           // write strobe
    input wire logic i_rd,                           // read strobe
    output logic [`DATA_W-1:0] o_rdata,              // read data, cycle after strobe
    input wire logic [`SEQ_COUNT-1:0] i_trig,        // trigger pulse per sequencer
    output logic o_conv_start,                       // converter start pulse
    output adc_seq_pkg::sel_t o_conv_input,          // analog input for this start
    input wire logic i_conv_done,                    // converter finished pulse
    input wire adc_seq_pkg::result_t i_conv_data,    // result beside done
    output logic o_irq                               // level interrupt
);

    localparam adc_seq_pkg::ctl_st_s ST_RST = '{
        seq1_sample_control: `CTL12_RST,
        seq2_sample_control: `CTL12_RST,
        seq3_sample_control: `CTL3_RST,
        default: '0
    };

    adc_seq_pkg::ctl_st_s st_ff;
    adc_seq_pkg::ctl_st_s nxt_st;

    adc_seq_pkg::seq_cfg_s [`SEQ_COUNT-1:0] seq_cfg;
    logic [`SEQ_COUNT-1:0][`SAMPLES_MAX-1:0][`SEL_W-1:0] seq_insel;
    adc_seq_pkg::walker_out_s [`SEQ_COUNT-1:0] wout;
    logic [`SEQ_COUNT-1:0] grant;
    logic [`SEQ_COUNT-1:0] done;

    // fifo depth of a sequencer
    function automatic logic [`CNT_W-1:0] depth_of(input int k);
        if (k == `SEQ_COUNT - 1) begin
            depth_of = `CNT_W'(`FIFO_DEPTH_3);
        end else begin
            depth_of = `CNT_W'(`FIFO_DEPTH_12);
        end
    endfunction

    // pointer advance with wrap at the sequencer's depth
    function automatic logic [`PTR_W-1:0] ptr_inc(input logic [`PTR_W-1:0] ptr, input logic [`CNT_W-1:0] dep);
        if ({1'b0, ptr} == dep - 1'b1) begin
            ptr_inc = '0;
        end else begin
            ptr_inc = ptr + 1'b1;
        end
    endfunction

    // result fifo read address of a sequencer
    function automatic logic [ADDR_W-1:0] fifo_ofs(input int k);
        if (k == 0) begin
            fifo_ofs = ADDR_W'(`OFS_SEQ1_FIFO);
        end else if (k == 1) begin
            fifo_ofs = ADDR_W'(`OFS_SEQ2_FIFO);
        end else begin
            fifo_ofs = ADDR_W'(`OFS_SEQ3_FIFO);
        end
    endfunction

    // fifo status word: full, empty, head and tail pointers
    function automatic logic [`DATA_W-1:0] fstat_of(input adc_seq_pkg::ctl_st_s s, input int k);
        logic [`DATA_W-1:0] w;
        w = '0;
        w[`FSTAT_FULL_BIT] = (s.level[k] == depth_of(k));
        w[`FSTAT_EMPTY_BIT] = (s.level[k] == '0);
        w[`FSTAT_HPTR_LSB +: `PTR_W] = s.head[k];
        w[0 +: `PTR_W] = s.tail[k];
        fstat_of = w;
    endfunction

    // unpack control registers into per-sample flags and selects
    always_comb begin
        seq_cfg = '0;
        seq_insel = '0;
        for (int j = 0; j < `SAMPLES_MAX; j++) begin
            seq_cfg[0].irq_enable[j] = st_ff.seq1_sample_control[`CTL_IE0_BIT + `CTL_STRIDE * j];
            seq_cfg[0].is_last[j] = st_ff.seq1_sample_control[`CTL_LAST0_BIT + `CTL_STRIDE * j];
            seq_cfg[1].irq_enable[j] = st_ff.seq2_sample_control[`CTL_IE0_BIT + `CTL_STRIDE * j];
            seq_cfg[1].is_last[j] = st_ff.seq2_sample_control[`CTL_LAST0_BIT + `CTL_STRIDE * j];
            seq_insel[0][j] = st_ff.seq1_input_select[`CTL_STRIDE * j +: `SEL_W];
            seq_insel[1][j] = st_ff.seq2_input_select[`CTL_STRIDE * j +: `SEL_W];
        end
        seq_cfg[0].single_sample_per_trigger = st_ff.seq1_sample_control[`CTL_SINGLE_BIT];
        seq_cfg[1].single_sample_per_trigger = st_ff.seq2_sample_control[`CTL_SINGLE_BIT];
        // sequencer 3 has only the first sample's flags
        seq_cfg[2].irq_enable[0] = st_ff.seq3_sample_control[`CTL_IE0_BIT];
        seq_cfg[2].is_last[0] = st_ff.seq3_sample_control[`CTL_LAST0_BIT];
        seq_insel[2][0] = st_ff.seq3_input_select;
    end

    // one walker per sequencer, sequencer 3 with a single position
    for (genvar g = 0; g < `SEQ_COUNT; g++) begin : g_seq
        seq_walker #(
            .SAMPLES((g == `SEQ_COUNT - 1) ? `SAMPLES_3 : `SAMPLES_12)
        ) u_walker (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_trig(i_trig[g]),
            .i_cfg(seq_cfg[g]),
            .i_input_sel(seq_insel[g]),
            .i_grant(grant[g]),
            .i_done(done[g]),
            .o_out(wout[g])
        );
    end

    // register file, converter arbitration, fifos and interrupt status
    always_comb begin
        logic [`IRQ_W-1:0] clr;
        logic [`IRQ_W-1:0] ev;
        logic pop;
        logic full;
        logic push_ok;
        nxt_st = st_ff;
        clr = '0;
        ev = '0;
        pop = 1'b0;
        full = 1'b0;
        push_ok = 1'b0;
        grant = '0;
        done = '0;
        nxt_st.conv_start = 1'b0;
        nxt_st.rdata = '0;

        // writes: only defined bits stored, reserved bits dropped
        if (i_wr) begin
            if (i_addr == ADDR_W'(`OFS_SEQ1_CTL)) begin
                nxt_st.seq1_sample_control = i_wdata[`REG12_W-1:0] & `CTL12_WMASK;
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_CTL)) begin
                nxt_st.seq2_sample_control = i_wdata[`REG12_W-1:0] & `CTL12_WMASK;
            end else if (i_addr == ADDR_W'(`OFS_SEQ1_INSEL)) begin
                nxt_st.seq1_input_select = i_wdata[`REG12_W-1:0] & `INSEL12_WMASK;
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_INSEL)) begin
                nxt_st.seq2_input_select = i_wdata[`REG12_W-1:0] & `INSEL12_WMASK;
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_INSEL)) begin
                nxt_st.seq3_input_select = i_wdata[`SEL_W-1:0];
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_CTL)) begin
                nxt_st.seq3_sample_control = i_wdata[2:0] & `CTL3_WMASK;
            end else if (i_addr == ADDR_W'(`OFS_IRQ_STATUS)) begin
                clr = i_wdata[`IRQ_W-1:0];
            end else if (i_addr == ADDR_W'(`OFS_IRQ_MASK)) begin
                nxt_st.irq_mask = i_wdata[`IRQ_W-1:0];
            end
        end

        // reads: registered, zero above the field and on unmapped offsets
        if (i_rd) begin
            if (i_addr == ADDR_W'(`OFS_SEQ1_CTL)) begin
                nxt_st.rdata = {16'h0000, st_ff.seq1_sample_control};
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_CTL)) begin
                nxt_st.rdata = {16'h0000, st_ff.seq2_sample_control};
            end else if (i_addr == ADDR_W'(`OFS_SEQ1_INSEL)) begin
                nxt_st.rdata = {16'h0000, st_ff.seq1_input_select};
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_INSEL)) begin
                nxt_st.rdata = {16'h0000, st_ff.seq2_input_select};
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_INSEL)) begin
                nxt_st.rdata = {29'h0000000, st_ff.seq3_input_select};
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_CTL)) begin
                nxt_st.rdata = {29'h0000000, st_ff.seq3_sample_control};
            end else if (i_addr == ADDR_W'(`OFS_SEQ1_FIFO)) begin
                nxt_st.rdata = {22'h000000, st_ff.fifo[0][st_ff.tail[0]]};
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_FIFO)) begin
                nxt_st.rdata = {22'h000000, st_ff.fifo[1][st_ff.tail[1]]};
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_FIFO)) begin
                nxt_st.rdata = {22'h000000, st_ff.fifo[2][st_ff.tail[2]]};
            end else if (i_addr == ADDR_W'(`OFS_SEQ1_FSTAT)) begin
                nxt_st.rdata = fstat_of(st_ff, 0);
            end else if (i_addr == ADDR_W'(`OFS_SEQ2_FSTAT)) begin
                nxt_st.rdata = fstat_of(st_ff, 1);
            end else if (i_addr == ADDR_W'(`OFS_SEQ3_FSTAT)) begin
                nxt_st.rdata = fstat_of(st_ff, 2);
            end else if (i_addr == ADDR_W'(`OFS_IRQ_STATUS)) begin
                nxt_st.rdata = {26'h0000000, st_ff.irq_status};
            end else if (i_addr == ADDR_W'(`OFS_IRQ_MASK)) begin
                nxt_st.rdata = {26'h0000000, st_ff.irq_mask};
            end
        end

        // one converter shared; sequencer 1 wins, then 2, then 3
        if (!st_ff.busy) begin
            if (wout[0].req) begin
                grant[0] = 1'b1;
                nxt_st.owner = 2'h0;
            end else if (wout[1].req) begin
                grant[1] = 1'b1;
                nxt_st.owner = 2'h1;
            end else if (wout[2].req) begin
                grant[2] = 1'b1;
                nxt_st.owner = 2'h2;
            end
            if (|grant) begin
                nxt_st.busy = 1'b1;
                nxt_st.conv_start = 1'b1;
                nxt_st.conv_input = wout[nxt_st.owner].input_sel;
            end
        end else if (i_conv_done) begin
            // a done outside a conversion is ignored
            nxt_st.busy = 1'b0;
            done[st_ff.owner] = 1'b1;
        end

        // result fifos: a read pops, a finished sample pushes
        for (int k = 0; k < `SEQ_COUNT; k++) begin
            pop = i_rd && (i_addr == fifo_ofs(k)) && (st_ff.level[k] != '0);
            full = (st_ff.level[k] == depth_of(k));
            // a full fifo still takes a result when a pop frees a slot this cycle
            push_ok = wout[k].sample_done && (!full || pop);
            if (pop) begin
                nxt_st.tail[k] = ptr_inc(st_ff.tail[k], depth_of(k));
            end
            if (push_ok) begin
                nxt_st.fifo[k][st_ff.head[k]] = i_conv_data;
                nxt_st.head[k] = ptr_inc(st_ff.head[k], depth_of(k));
            end
            nxt_st.level[k] = st_ff.level[k] + `CNT_W'(push_ok) - `CNT_W'(pop);
            // dropped result flags overflow instead of overwriting
            ev[`IRQ_OVF_LSB + k] = wout[k].sample_done && !push_ok;
            ev[k] = wout[k].sample_irq;
        end

        // sticky status, write one to clear, a new event wins over the clear
        nxt_st.irq_status = (st_ff.irq_status & ~clr) | ev;
        nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
    end

    // all state in one register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign o_rdata = st_ff.rdata;
    assign o_conv_start = st_ff.conv_start;
    assign o_conv_input = st_ff.conv_input;
    assign o_irq = st_ff.irq;

endmodule

// file: test/adc_seq_ctl_chk.sv
`timescale 1ns/1ps
module adc_seq_ctl_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,                       // system clock
    input wire logic i_rst_n,                     // sync reset, active low
    input wire logic [ADDR_W-1:0] i_addr,         // register address
    input wire logic [31:0] i_wdata,              // write data
    input wire logic i_wr,                        // write strobe
    input wire logic i_rd,                        // read strobe
    input wire logic [31:0] o_rdata,              // read data
    input wire logic o_conv_start,                // converter start
    input wire adc_seq_pkg::sel_t o_conv_input    // converter input
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // a read strobe at one address; a write to 0x74 followed at once by a read there
    sequence rd_at(a);
        i_rd && i_addr == a;
    endsequence
    sequence wr_then_rd;
        i_wr && i_addr == 8'h74 ##1 i_rd && i_addr == 8'h74;
    endsequence

    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_ctl1_resv: assert property (rd_at(8'h74) |=> (o_rdata & ~32'h6667) == 32'h0)
        else $error("seq1 control reserved bits not zero");
    chk_ctl2_resv: assert property (rd_at(8'h94) |=> (o_rdata & ~32'h6667) == 32'h0)
        else $error("seq2 control reserved bits not zero");
    chk_sel3_resv: assert property (rd_at(8'hb0) |=> o_rdata[31:3] == 29'h0)
        else $error("seq3 input select reserved bits not zero");
    chk_ctl3_resv: assert property (rd_at(8'hb4) |=> (o_rdata & ~32'h6) == 32'h0)
        else $error("seq3 control reserved bits not zero");
    chk_fifo_width: assert property (rd_at(8'h78) |=> o_rdata[31:10] == 22'h0)
        else $error("result upper bits not zero");
    chk_ctl_writeback: assert property (wr_then_rd |=> o_rdata == ($past(i_wdata, 2) & 32'h6667))
        else $error("seq1 control write not read back");
    chk_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse longer than one cycle");
    chk_input_hold: assert property (!o_conv_start |-> $stable(o_conv_input))
        else $error("input select changed without a start");
endmodule

bind adc_sample_sequence_control adc_seq_ctl_chk #(.ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_start(o_conv_start), .o_conv_input(o_conv_input));

// file: test/test_adc_sample_sequence_control.sv
`timescale 1ns/1ps
module test_adc_sample_sequence_control;
    logic i_clk, i_rst_n, i_wr, i_rd, i_conv_done, o_conv_start, o_irq;
    logic [7:0] i_addr, a, b;
    logic [31:0] i_wdata, o_rdata, lf;
    logic [2:0] i_trig;
    adc_seq_pkg::sel_t o_conv_input;
    adc_seq_pkg::result_t i_conv_data;
    adc_seq_pkg::result_t exp_q[$];
    logic [7:0] addrs [4] = '{8'h74, 8'h94, 8'hb0, 8'hb4};
    int n_errors = 0, n_tests = 0, n_starts = 0, i, j, p;

    adc_sample_sequence_control u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig(i_trig), .o_conv_start(o_conv_start),
        .o_conv_input(o_conv_input), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_irq(o_irq));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // counts starts so that an extra or a missing sample shows up
    always @(posedge i_clk) begin
        if (i_rst_n && o_conv_start === 1'b1) n_starts <= n_starts + 1;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // writable bits of each register in addrs
    function automatic logic [31:0] wmask(input logic [7:0] ra);
        case (ra)
            8'h74, 8'h94: return 32'h6667;
            8'hb0: return 32'h7;
            default: return 32'h6;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one bus cycle; a write leaves its strobe up until the next cycle lowers it
    task automatic bus(input logic w, r, input logic [7:0] ra, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= r;
        i_addr <= ra;
        i_wdata <= d;
    endtask

    task automatic wr_reg(input logic [7:0] ra, input logic [31:0] d);
        bus(1'b1, 1'b0, ra, d);
    endtask

    task automatic rd_chk(input logic [7:0] ra, input logic [31:0] exp, input string what);
        bus(1'b0, 1'b1, ra, 32'h0);
        bus(1'b0, 1'b0, ra, 32'h0);
        #1;
        check(what, exp, o_rdata);
    endtask

    task automatic trigger(input logic [2:0] m);
        @(posedge i_clk);
        i_trig <= m;
        i_wr <= 1'b0;
        @(posedge i_clk);
        i_trig <= 3'h0;
    endtask

    // acts as the converter: answers n starts, checks each chosen input
    task automatic serve(input int n, input logic [15:0] sel, input int pos);
        int k, w, s0;
        s0 = n_starts;
        for (k = pos; k < pos + n; k++) begin
            #1;
            for (w = 0; w < 20 && o_conv_start !== 1'b1; w++) begin
                @(posedge i_clk);
                #1;
            end
            check("conv_input", 32'(sel[4*k +: 3]), 32'(o_conv_input));
            lf = lfsr(lf);
            exp_q.push_back(lf[9:0]);
            @(posedge i_clk);
            i_conv_done <= 1'b1;
            i_conv_data <= lf[9:0];
            @(posedge i_clk);
            i_conv_done <= 1'b0;
        end
        repeat (10) @(posedge i_clk);
        #1;
        check("start_count", n, n_starts - s0);
    endtask

    task automatic drain(input logic [7:0] fa);
        while (exp_q.size() > 0) rd_chk(fa, 32'(exp_q.pop_front()), "fifo_data");
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        {i_rst_n, i_wr, i_rd, i_conv_done, i_trig, i_addr, i_wdata, i_conv_data} = '0;
        lf = 32'hacfdfdf7;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd_chk(8'h74, 32'h2000, "seq1_ctl_reset");
        rd_chk(8'h94, 32'h2000, "seq2_ctl_reset");
        rd_chk(8'hb0, 32'h0, "seq3_sel_reset");
        rd_chk(8'hb4, 32'h2, "seq3_ctl_reset");
        rd_chk(8'h00, 32'h0, "unmapped_read");
        rd_chk(8'h7c, 32'h100, "seq1_fstat_reset");
        // random words, read straight back through the writable masks
        for (i = 0; i < 16; i++) begin
            a = addrs[i % 4];
            lf = lfsr(lf);
            wr_reg(a, lf);
            rd_chk(a, lf & wmask(a), "rw_mask");
        end
        // every end position, enable off or on, interrupt masked or not, both sequencers
        for (p = 0; p < 3; p++) begin
            for (j = 0; j < 4; j++) begin
                b = 8'h70 + 8'(32 * (p % 2));
                lf = lfsr(lf);
                wr_reg(b, lf & 32'h7777);
                wr_reg(b + 8'h4, (32'h2 | (p != 0 ? 32'h4 : 32'h0)) << (4 * j));
                wr_reg(8'hc4, 32'(p != 1) << (p % 2));
                trigger(3'(1 << (p % 2)));
                serve(j + 1, lf[15:0], 0);
                check("irq", 32'(p == 2), 32'(o_irq));
                rd_chk(8'hc0, 32'(p != 0) << (p % 2), "irq_status");
                wr_reg(8'hc0, 32'h3f);
                drain(b + 8'h8);
                check("irq_cleared", 32'h0, 32'(o_irq));
            end
        end
        // one sample per trigger, position carries over and wraps after the end
        wr_reg(8'h70, 32'h0765);
        wr_reg(8'h74, 32'h0201);
        for (j = 0; j < 4; j++) begin
            trigger(3'h1);
            serve(1, 16'h0765, j % 3);
        end
        drain(8'h78);
        // single-sample sequencer with its own select and interrupt enable
        wr_reg(8'hb0, 32'h5);
        wr_reg(8'hb4, 32'h6);
        wr_reg(8'hc4, 32'h4);
        trigger(3'h4);
        serve(1, 16'h5, 0);
        check("irq_seq3", 32'h1, 32'(o_irq));
        wr_reg(8'hc0, 32'h4);
        rd_chk(8'hbc, 32'h1000, "seq3_fstat_full");
        drain(8'hb8);
        check("irq_seq3_cleared", 32'h0, 32'(o_irq));
        tally_and_finish;
    end
endmodule
